// file: verilog/pmicpr_regs.sv
// Purpose: Privileged control register bank of the power manager
// Assumes: Byte register port from the serial engine, inputs synchronous to clk_sys
// Notes: Privileged mode, once entered, is left only by reset
`timescale 1ns/1ns
module pmicpr_regs #(
  parameter int GPIO_W = 8,
  parameter int FUSE_DEPTH = 16,
  parameter int FUSE_IDX_W = 4,
  parameter int BASE_LAYER_CHANGES = 1,
  parameter int METAL_CHANGES = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [6:0] rail3_actual_voltage_code,
  input wire logic rail_low_raw,
  output logic rail_low_fault,
  input wire logic [GPIO_W-1:0] gpio_out_val,
  output logic [GPIO_W-1:0] gpio_o,
  output logic [GPIO_W-1:0] gpio_oe_n,
  output logic output_drive_select,
  output logic system_monitor_on,
  output logic system_warning_on,
  output logic low_output_check_mask,
  output logic priv_mode,
  output logic fuse_reload_busy,
  output logic [FUSE_IDX_W-1:0] fuse_rd_addr,
  input wire logic [7:0] fuse_rd_data
);
  // Unlock sequence states
  typedef enum logic [1:0] {
    PMICPR_UL_WAIT_FIRST,
    PMICPR_UL_WAIT_SECOND,
    PMICPR_UL_OPEN
  } pmicpr_unlock_e;

  // Revision nibbles fixed at build time
  localparam logic [3:0] BASE_NIBBLE = (BASE_LAYER_CHANGES == 0) ? pmicpr_pkg::BASE_REV_NONE :
    pmicpr_pkg::BASE_REV_FIRST + 4'((BASE_LAYER_CHANGES - 1) % pmicpr_pkg::BASE_REV_SPAN);
  localparam logic [3:0] METAL_NIBBLE = 4'(METAL_CHANGES % pmicpr_pkg::METAL_REV_SPAN);

  pmicpr_unlock_e unlock_reg; // Unlock tracker
  pmicpr_unlock_e unlock_next;
  logic [3:0] top_reg; // Top control bits 7:4
  logic [3:0] top_next;
  logic reload_reg; // Fuse reload trigger bit
  logic reload_next;
  logic [7:0] key_reg; // Last byte written to the key register
  logic [7:0] key_next;

  // Carrier to the fuse engine
  pmicpr_fuse_if #(.IDX_W(FUSE_IDX_W)) fuse ();

  // Address decode
  wire sel_rev = (reg_addr == pmicpr_pkg::OFS_SILICON_REVISION);
  wire sel_top = (reg_addr == pmicpr_pkg::OFS_TOP_CONTROL);
  wire sel_rail = (reg_addr == pmicpr_pkg::OFS_RAIL3_ACTUAL_VOLTAGE);
  wire sel_reload = (reg_addr == pmicpr_pkg::OFS_FUSE_RELOAD);
  wire sel_status = (reg_addr == pmicpr_pkg::OFS_PRIV_MODE_STATUS);
  wire sel_key = (reg_addr == pmicpr_pkg::OFS_UNLOCK_KEY);
  wire unlocked = (unlock_reg == PMICPR_UL_OPEN);

  // Privileged registers only answer once unlocked
  wire wr_top = reg_wr & sel_top & unlocked;
  wire wr_reload = reg_wr & sel_reload & unlocked;
  wire wr_key = reg_wr & sel_key;
  wire reload_start = wr_reload & reg_wdata[pmicpr_pkg::FUSE_RELOAD_BIT] & ~reload_reg;
  wire fuse_top_load = fuse.load_valid & (fuse.load_index == FUSE_IDX_W'(pmicpr_pkg::FUSE_IDX_TOP_CONTROL));

  // Rail 3 code saturation, codes past the top report 1.30 V
  wire rail_over = (rail3_actual_voltage_code > pmicpr_pkg::RAIL3_CODE_MAX);
  wire [6:0] rail_code_sat = rail_over ? pmicpr_pkg::RAIL3_CODE_MAX : rail3_actual_voltage_code;

  // Readback selection; locked privileged registers read zero
  wire [7:0] rd_rev = {BASE_NIBBLE, METAL_NIBBLE};
  wire [7:0] rd_top = unlocked ? {top_reg, 4'h0} : 8'h00;
  wire [7:0] rd_rail = {rail_code_sat, 1'b0};
  wire [7:0] rd_reload = unlocked ? {7'h00, reload_reg} : 8'h00;
  wire [7:0] rd_status = {1'b0, unlocked, 6'h00};
  wire [7:0] rd_mux = sel_rev ? rd_rev :
                      sel_top ? rd_top :
                      sel_rail ? rd_rail :
                      sel_reload ? rd_reload :
                      sel_status ? rd_status :
                      sel_key ? key_reg : 8'h00;

  // Unlock sequence tracker
  always_comb begin
    unlock_next = unlock_reg;
    case (unlock_reg)
      PMICPR_UL_WAIT_FIRST: begin
        if (wr_key && reg_wdata == pmicpr_pkg::UNLOCK_FIRST_BYTE) begin
          unlock_next = PMICPR_UL_WAIT_SECOND;
        end
      end
      PMICPR_UL_WAIT_SECOND: begin
        if (wr_key) begin
          if (reg_wdata == pmicpr_pkg::UNLOCK_SECOND_BYTE) begin
            unlock_next = PMICPR_UL_OPEN;
          end else if (reg_wdata == pmicpr_pkg::UNLOCK_FIRST_BYTE) begin
            // A repeated first byte counts as a fresh start
            unlock_next = PMICPR_UL_WAIT_SECOND;
          end else begin
            unlock_next = PMICPR_UL_WAIT_FIRST;
          end
        end
      end
      PMICPR_UL_OPEN: begin
        // Sticky until reset; later key writes do not relock
        unlock_next = PMICPR_UL_OPEN;
      end
      default: begin
        unlock_next = PMICPR_UL_WAIT_FIRST;
      end
    endcase
  end

  // Top control, reload bit and key next values
  always_comb begin
    top_next = top_reg;
    reload_next = reload_reg;
    key_next = key_reg;
    // Fuse image first, host write overrides in the same cycle
    if (fuse_top_load) begin
      top_next = fuse.load_data[7:pmicpr_pkg::TOP_FIELD_LSB];
    end
    if (wr_top) begin
      top_next = reg_wdata[7:pmicpr_pkg::TOP_FIELD_LSB];
    end
    if (reload_start) begin
      reload_next = 1'b1;
    end else if (fuse.done) begin
      reload_next = 1'b0;
    end
    if (wr_key) begin
      key_next = reg_wdata;
    end
  end

  // State registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      unlock_reg <= PMICPR_UL_WAIT_FIRST;
      top_reg <= pmicpr_pkg::TOP_CONTROL_RESET;
      reload_reg <= 1'b0;
      key_reg <= pmicpr_pkg::UNLOCK_KEY_RESET;
    end else if (ce) begin
      unlock_reg <= unlock_next;
      top_reg <= top_next;
      reload_reg <= reload_next;
      key_reg <= key_next;
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // Control outputs, registered copies of the bank state, and the registered masked low fault
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      output_drive_select <= 1'b0;
      system_monitor_on <= 1'b1;
      system_warning_on <= 1'b1;
      low_output_check_mask <= 1'b1;
      priv_mode <= 1'b0;
      fuse_reload_busy <= 1'b0;
      rail_low_fault <= 1'b0;
    end else if (ce) begin
      output_drive_select <= top_next[pmicpr_pkg::TOP_DRIVE_SELECT_BIT - pmicpr_pkg::TOP_FIELD_LSB];
      system_monitor_on <= top_next[pmicpr_pkg::TOP_MONITOR_ON_BIT - pmicpr_pkg::TOP_FIELD_LSB];
      system_warning_on <= top_next[pmicpr_pkg::TOP_WARNING_ON_BIT - pmicpr_pkg::TOP_FIELD_LSB];
      low_output_check_mask <= top_next[pmicpr_pkg::TOP_LOW_MASK_BIT - pmicpr_pkg::TOP_FIELD_LSB];
      priv_mode <= (unlock_next == PMICPR_UL_OPEN);
      fuse_reload_busy <= reload_next;
      // Masked check never reports a low output
      rail_low_fault <= rail_low_raw & ~top_reg[pmicpr_pkg::TOP_LOW_MASK_BIT - pmicpr_pkg::TOP_FIELD_LSB];
    end
  end

  // Pad drivers; open drain only pulls low, so enable follows the value
  genvar gi;
  generate
    for (gi = 0; gi < GPIO_W; gi = gi + 1) begin : g_pad
      wire pp = top_reg[pmicpr_pkg::TOP_DRIVE_SELECT_BIT - pmicpr_pkg::TOP_FIELD_LSB];
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          gpio_o[gi] <= 1'b0;
          gpio_oe_n[gi] <= 1'b1;
        end else if (ce) begin
          gpio_o[gi] <= pp ? gpio_out_val[gi] : 1'b0;
          gpio_oe_n[gi] <= pp ? 1'b0 : gpio_out_val[gi];
        end
      end
    end
  endgenerate

  assign fuse.start = reload_start;

  // Fuse walker
  pmicpr_fuse_engine #(
    .FUSE_DEPTH(FUSE_DEPTH),
    .IDX_W(FUSE_IDX_W)
  ) u_fuse (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .fuse(fuse),
    .fuse_rd_addr(fuse_rd_addr),
    .fuse_rd_data(fuse_rd_data)
  );
endmodule // pmicpr_regs

// file: verilog/pmicpr_pkg.sv
// Purpose: Shared constants of the privileged control register bank
// Assumes: Byte-wide register port driven by the serial interface engine
// Notes: Offsets are byte addresses of the 8-bit register space
package pmicpr_pkg;
  // Register offsets
  localparam logic [7:0] OFS_SILICON_REVISION = 8'h3b;
  localparam logic [7:0] OFS_TOP_CONTROL = 8'h3c;
  localparam logic [7:0] OFS_RAIL3_ACTUAL_VOLTAGE = 8'h3d;
  localparam logic [7:0] OFS_FUSE_RELOAD = 8'h3e;
  localparam logic [7:0] OFS_PRIV_MODE_STATUS = 8'hf0;
  localparam logic [7:0] OFS_UNLOCK_KEY = 8'hf1;

  // Top control field positions
  localparam int TOP_DRIVE_SELECT_BIT = 7;
  localparam int TOP_MONITOR_ON_BIT = 6;
  localparam int TOP_WARNING_ON_BIT = 5;
  localparam int TOP_LOW_MASK_BIT = 4;
  localparam int TOP_FIELD_LSB = 4;
  localparam logic [3:0] TOP_CONTROL_RESET = 4'h7;

  // Fuse reload and status field positions
  localparam int FUSE_RELOAD_BIT = 0;
  localparam int PRIV_STATUS_BIT = 6;
  localparam logic [7:0] PRIV_STATUS_RESET = 8'h00;
  localparam logic [7:0] UNLOCK_KEY_RESET = 8'h00;

  // Unlock sequence bytes
  localparam logic [7:0] UNLOCK_FIRST_BYTE = 8'h24;
  localparam logic [7:0] UNLOCK_SECOND_BYTE = 8'h54;

  // Revision nibble encodings
  localparam logic [3:0] BASE_REV_FIRST = 4'ha;
  localparam int BASE_REV_SPAN = 6;
  localparam int METAL_REV_SPAN = 16;
  localparam logic [3:0] BASE_REV_NONE = 4'h0;

  // Rail 3 code saturation: 0.5 V plus 10 mV per code, top is 1.30 V
  localparam logic [6:0] RAIL3_CODE_MAX = 7'h50;

  // Fuse map index that restores the top control fields
  localparam int FUSE_IDX_TOP_CONTROL = 0;
endpackage : pmicpr_pkg

// file: verilog/pmicpr_fuse_if.sv
// Purpose: Carrier between register bank and fuse reload engine
// Assumes: Single clock domain
// Notes: Load strobes run back to back, one cycle per fuse word
`timescale 1ns/1ns
interface pmicpr_fuse_if #(
  parameter int IDX_W = 4
);
  logic start; // One-cycle request to walk the fuses
  logic busy; // Walk in progress
  logic done; // One-cycle pulse at the end of the walk
  logic load_valid; // One fuse word ready
  logic [IDX_W-1:0] load_index; // Fuse word index
  logic [7:0] load_data; // Fuse word value

  modport eng (input start, output busy, output done, output load_valid, output load_index, output load_data);
  modport ctl (output start, input busy, input done, input load_valid, input load_index, input load_data);
endinterface : pmicpr_fuse_if

// file: verilog/pmicpr_fuse_engine.sv
// Purpose: Walks every fuse word and hands each to the register bank
// Assumes: Fuse macro answers a read address with data in the same cycle, sampled at the next edge
// Notes: A start while busy is ignored
`timescale 1ns/1ns
module pmicpr_fuse_engine #(
  parameter int FUSE_DEPTH = 16,
  parameter int IDX_W = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  pmicpr_fuse_if.eng fuse,
  output logic [IDX_W-1:0] fuse_rd_addr,
  input wire logic [7:0] fuse_rd_data
);
  // Walk states
  typedef enum logic [1:0] {
    PMICPR_FE_IDLE,
    PMICPR_FE_READ,
    PMICPR_FE_FINISH
  } pmicpr_fe_state_e;

  pmicpr_fe_state_e state_reg;
  pmicpr_fe_state_e state_next;
  logic [IDX_W-1:0] addr_reg; // Address in flight
  logic [IDX_W-1:0] addr_next;
  logic pend_reg; // Data for addr_reg arrives this cycle
  logic pend_next;
  logic last_addr;

  assign last_addr = (addr_reg == IDX_W'(FUSE_DEPTH - 1));

  // Next state of the walk
  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    pend_next = 1'b0;
    case (state_reg)
      PMICPR_FE_IDLE: begin
        if (fuse.start) begin
          state_next = PMICPR_FE_READ;
          addr_next = '0;
          pend_next = 1'b1;
        end
      end
      PMICPR_FE_READ: begin
        if (last_addr) begin
          state_next = PMICPR_FE_FINISH;
        end else begin
          addr_next = addr_reg + 1'b1;
          pend_next = 1'b1;
        end
      end
      PMICPR_FE_FINISH: begin
        state_next = PMICPR_FE_IDLE;
      end
      default: begin
        state_next = PMICPR_FE_IDLE;
      end
    endcase
  end

  // Walk registers; clock enable freezes everything
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= PMICPR_FE_IDLE;
      addr_reg <= '0;
      pend_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      pend_reg <= pend_next;
    end
  end

  // Load strobe follows the read address by one cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fuse.load_valid <= 1'b0;
      fuse.load_index <= '0;
      fuse.load_data <= 8'h00;
      fuse.done <= 1'b0;
    end else if (ce) begin
      fuse.load_valid <= pend_reg;
      fuse.load_index <= addr_reg;
      fuse.load_data <= fuse_rd_data;
      fuse.done <= (state_reg == PMICPR_FE_FINISH);
    end
  end

  assign fuse.busy = (state_reg != PMICPR_FE_IDLE);
  assign fuse_rd_addr = addr_reg;
endmodule // pmicpr_fuse_engine

// file: test/pmicpr_regs_chk.sv
// Purpose: Port checks of the privileged control register bank
// Assumes: One clock, checks qualified by ce except the reset, unlock cause and reload end checks
// Notes: Bound onto every pmicpr_regs instance
`timescale 1ns/1ns
module pmicpr_regs_chk #(
  parameter int GPIO_W = 8,
  parameter int FUSE_IDX_W = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [6:0] rail3_actual_voltage_code,
  input wire logic rail_low_raw,
  input wire logic rail_low_fault,
  input wire logic [GPIO_W-1:0] gpio_out_val,
  input wire logic [GPIO_W-1:0] gpio_o,
  input wire logic [GPIO_W-1:0] gpio_oe_n,
  input wire logic output_drive_select,
  input wire logic system_monitor_on,
  input wire logic system_warning_on,
  input wire logic low_output_check_mask,
  input wire logic priv_mode,
  input wire logic fuse_reload_busy,
  input wire logic [FUSE_IDX_W-1:0] fuse_rd_addr
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Decoded host strobes
  wire logic wr_key = ce && reg_wr && reg_addr == 8'hf1;
  wire logic key_one = wr_key && reg_wdata == 8'h24;
  wire logic key_two = wr_key && reg_wdata == 8'h54;
  wire logic gated = reg_addr == 8'h3c || reg_addr == 8'h3e;
  wire logic locked_wr = ce && reg_wr && !priv_mode && gated;
  wire logic go_reload = ce && reg_wr && priv_mode && reg_addr == 8'h3e && reg_wdata[0] && !fuse_reload_busy;
  reset_fields_a: assert property ($fell(rst) |-> !output_drive_select && system_monitor_on && system_warning_on
    && low_output_check_mask) else $error("top control not at reset pattern");
  unlock_pair_a: assert property (key_one ##1 key_two |=> priv_mode) else $error("key pair did not unlock");
  unlock_cause_a: assert property ($rose(priv_mode) |-> $past(key_two)) else $error("unlock without key");
  locked_write_a: assert property (locked_wr |=> $stable(output_drive_select) && $stable(low_output_check_mask)
    && !fuse_reload_busy) else $error("locked write took effect");
  locked_read_a: assert property (ce && reg_rd && !priv_mode && gated |=> reg_rdata == 8'h00)
    else $error("locked read leaked data");
  status_read_a: assert property (ce && reg_rd && reg_addr == 8'hf0 |=> reg_rdata == {1'b0, $past(priv_mode), 6'h00})
    else $error("status read wrong");
  rail3_read_a: assert property (ce && reg_rd && reg_addr == 8'h3d |=> reg_rdata ==
    {(($past(rail3_actual_voltage_code) > 7'h50) ? 7'h50 : $past(rail3_actual_voltage_code)), 1'b0})
    else $error("rail 3 code wrong");
  open_drain_a: assert property (ce && !output_drive_select |=> gpio_o == '0 && gpio_oe_n == $past(gpio_out_val))
    else $error("pads not open drain");
  push_pull_a: assert property (ce && output_drive_select |=> gpio_oe_n == '0 && gpio_o == $past(gpio_out_val))
    else $error("pads not push-pull");
  mask_skip_a: assert property (ce && low_output_check_mask |=> !rail_low_fault) else $error("masked low seen");
  low_check_a: assert property (ce && !low_output_check_mask && rail_low_raw |=> rail_low_fault)
    else $error("low output missed");
  reload_start_a: assert property (go_reload |=> fuse_reload_busy && fuse_rd_addr == '0)
    else $error("reload did not start");
  reload_end_a: assert property ($rose(fuse_reload_busy) |-> ##[1:40] !fuse_reload_busy)
    else $error("reload bit stuck");
  // Main scenarios reached
  cover property (key_one ##1 key_two);
  cover property (locked_wr);
  cover property ($fell(fuse_reload_busy));
  cover property (output_drive_select && rail_low_fault);
endmodule // pmicpr_regs_chk
bind pmicpr_regs pmicpr_regs_chk #(.GPIO_W(GPIO_W), .FUSE_IDX_W(FUSE_IDX_W)) chk_u (.*);

// file: test/pmicpr_fuse_model.sv
// Purpose: Behavioural fuse array behind the reload engine
// Assumes: Data follows the address within the cycle, sampled at the next edge
// Notes: Word 0 holds the top control image, others a filler
`timescale 1ns/1ns
module pmicpr_fuse_model #(
  parameter logic [7:0] TOP_IMAGE = 8'h9f
) (
  input wire logic clk_sys,
  input wire logic [3:0] fuse_rd_addr,
  output logic [7:0] fuse_rd_data
);
  // Engine samples the word at the edge after the address flop, so the read is asynchronous
  // Filler follows the address so a stale word is visible
  always_comb begin
    fuse_rd_data = (fuse_rd_addr == 4'h0) ? TOP_IMAGE : {4'h5, fuse_rd_addr};
  end
endmodule // pmicpr_fuse_model

// file: test/test_pmicpr_regs.sv
// Purpose: Self-checking bench of the privileged control register bank
// Assumes: Inputs driven on the falling edge
// Notes: Revision parameters set at the wrap points
`timescale 1ns/1ns
module test_pmicpr_regs;
  logic clk_sys, rst, ce, reg_wr, reg_rd, reg_rvalid, rail_low_raw, rail_low_fault;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, gpio_out_val, gpio_o, gpio_oe_n, fuse_rd_data;
  logic output_drive_select, system_monitor_on, system_warning_on, low_output_check_mask;
  logic priv_mode, fuse_reload_busy;
  logic [6:0] rail3_actual_voltage_code;
  logic [3:0] fuse_rd_addr;
  int fail_count = 0;
  int samples_checked = 0;
  // Seven base and sixteen metal changes both wrap
  pmicpr_regs #(.BASE_LAYER_CHANGES(7), .METAL_CHANGES(16)) dut_u (.*);
  pmicpr_fuse_model fuse_u (.*);
  wire logic [7:0] top4 = {4'h0, output_drive_select, system_monitor_on, system_warning_on, low_output_check_mask};
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Leaves the strobe high so writes can run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_rd = 0;
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
  endtask
  task automatic idle();
    @(negedge clk_sys);
    reg_wr = 0;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clk_sys);
    reg_wr = 0;
    reg_rd = 1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 0;
    chk({what, " valid"}, 8'h01, {7'h0, reg_rvalid});
    chk(what, exp, reg_rdata);
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic t_reset();
    chk("top fields", 8'h07, top4);
    chk("fault", 8'h00, {7'h0, rail_low_fault});
    rd(8'h3b, 8'ha0, "revision");
    rd(8'hf0, 8'h00, "status");
    rd(8'hf1, 8'h00, "key");
    rd(8'h3c, 8'h00, "locked top");
    $display("test reset done");
  endtask
  task automatic t_locked();
    wr(8'h3c, 8'h80);
    wr(8'h3e, 8'h01);
    idle();
    chk("top fields", 8'h07, top4);
    chk("busy", 8'h00, {7'h0, fuse_reload_busy});
    // Broken key sequence
    wr(8'hf1, 8'h24);
    wr(8'hf1, 8'h11);
    wr(8'hf1, 8'h54);
    idle();
    chk("priv", 8'h00, {7'h0, priv_mode});
    rd(8'hf0, 8'h00, "status");
    $display("test locked done");
  endtask
  task automatic t_rail3();
    logic [6:0] codes [6] = '{7'h00, 7'h01, 7'h4f, 7'h50, 7'h51, 7'h7f};
    foreach (codes[i]) begin
      rail3_actual_voltage_code = codes[i];
      rd(8'h3d, {(codes[i] > 7'h50) ? 7'h50 : codes[i], 1'b0}, "rail3");
    end
    $display("test rail3 done");
  endtask
  task automatic t_unlock();
    wr(8'hf1, 8'h24);
    wr(8'hf1, 8'h24);
    wr(8'hf1, 8'h54);
    idle();
    chk("priv", 8'h01, {7'h0, priv_mode});
    rd(8'hf0, 8'h40, "status");
    $display("test unlock done");
  endtask
  task automatic t_top();
    wr(8'h3c, 8'h8f);
    idle();
    rd(8'h3c, 8'h80, "top");
    chk("oe_n", 8'h00, gpio_oe_n);
    chk("pads", 8'ha5, gpio_o);
    chk("fault", 8'h01, {7'h0, rail_low_fault});
    wr(8'h3c, 8'h10);
    idle();
    chk("oe_n", 8'ha5, gpio_oe_n);
    chk("pads", 8'h00, gpio_o);
    chk("fault", 8'h00, {7'h0, rail_low_fault});
    $display("test top done");
  endtask
  task automatic t_reload();
    int n;
    // Second pass starts with the walk address left at the last word
    repeat (2) begin
      wr(8'h3c, 8'h00);
      wr(8'h3e, 8'h01);
      idle();
      chk("busy", 8'h01, {7'h0, fuse_reload_busy});
      for (n = 0; n < 60 && fuse_reload_busy; n++) @(negedge clk_sys);
      if (fuse_reload_busy !== 1'b0) begin
        fail_count++;
        $display("mismatch reload wait expected 0 seen %b", fuse_reload_busy);
        end_sim();
      end
      chk("top fields", 8'h09, top4);
      rd(8'h3e, 8'h00, "reload");
      rd(8'h3c, 8'h90, "top");
    end
    $display("test reload done");
  endtask
  initial begin
    rst = 1;
    ce = 1;
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    rail3_actual_voltage_code = 7'h00;
    rail_low_raw = 1;
    gpio_out_val = 8'ha5;
    repeat (20) @(negedge clk_sys);
    rst = 0;
    t_reset();
    t_locked();
    t_rail3();
    t_unlock();
    t_top();
    t_reload();
    end_sim();
  end
endmodule // test_pmicpr_regs
